// [hw/mtd_pkg.sv]
// Constants, types and codes shared by both ends of the memory type decoder.
// Assumes one clock domain shared by the requesting end and the decoder.
//
// Functional notes
// R1 - Codes 0000-0011 map to device and normal-uncached types
// R2 - Read 1010/1110/1011/1111 map to cached types
// R3 - Write 0110/1110/0111/1111 map to cached types
// R4 - Older alternative codes accepted on each channel
// R5 - Unlisted codes flagged reserved
// R6 - Several codes per type; never reject any form
// R7 - Device unbuffered: response and data from destination
// R8 - Device types: no prefetch, no merge
// R9 - Non-modifiable same ID same slave stay ordered
// R10 - Device buffered: early response, data from destination
// R11 - Normal unbuffered: destination only, merge allowed
// R12 - Normal types: same ID overlapping stay ordered
// R13 - Normal buffered reads may forward newest write
// R14 - Normal buffered: early response, timely visible merges
// R15 - Cached types: lookup, cached reads, prefetch, merge
// R16 - Write-through: early response, write reaches destination
// R17 - Write-back: early response, destination visibility optional
// R18 - No-allocate is only a hint
// R19 - Report read and write allocation hints
// R20 - Attribute bit one marks modifiable
// R21 - Decoded results registered next edge, cleared on reset
package mtd_pkg;

  localparam int unsigned NUM_CH  = 2;
  localparam int unsigned CH_RD   = 0;
  localparam int unsigned CH_WR   = 1;
  localparam int unsigned CODE_W  = 4;
  localparam int unsigned BIT_MOD = 1;
  localparam int unsigned CNT_W   = 8;

  // Codes valid on both channels
  localparam logic [3:0] CODE_DEV_NB = 4'h0;
  localparam logic [3:0] CODE_DEV_B  = 4'h1;
  localparam logic [3:0] CODE_NRM_NB = 4'h2;
  localparam logic [3:0] CODE_NRM_B  = 4'h3;
  // Current cached codes
  localparam logic [3:0] CODE_WT_LO  = 4'h6;
  localparam logic [3:0] CODE_WB_LO  = 4'h7;
  localparam logic [3:0] CODE_WT_MID = 4'hA;
  localparam logic [3:0] CODE_WB_MID = 4'hB;
  localparam logic [3:0] CODE_WT_HI  = 4'hE;
  localparam logic [3:0] CODE_WB_HI  = 4'hF;

  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;

  typedef enum logic [3:0] {
    MT_DEV_NB = 4'h0,
    MT_DEV_B  = 4'h1,
    MT_NRM_NB = 4'h2,
    MT_NRM_B  = 4'h3,
    MT_WT_NA  = 4'h4,
    MT_WT_RA  = 4'h5,
    MT_WT_WA  = 4'h6,
    MT_WT_RWA = 4'h7,
    MT_WB_NA  = 4'h8,
    MT_WB_RA  = 4'h9,
    MT_WB_WA  = 4'hA,
    MT_WB_RWA = 4'hB
  } mtd_mem_e;

  typedef struct packed {
    logic resp_final;
    logic rd_final;
    logic rd_fwd;
    logic rd_cached;
    logic modif;
    logic pf_ok;
    logic merge_ok;
    logic lookup;
    logic ord_slave;
    logic ord_overlap;
    logic wr_visible;
    logic alloc_rd;
    logic alloc_wr;
  } mtd_duty_s;

endpackage : mtd_pkg

// [hw/mtd_if.sv]
// Link between the requesting end and the decoder end.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/10ps
interface mtd_if;
  import mtd_pkg::*;

  logic [NUM_CH-1:0] cvalid;
  logic [CODE_W-1:0] code   [NUM_CH];
  logic [NUM_CH-1:0] dvalid;
  logic [NUM_CH-1:0] rsvd;
  mtd_mem_e          mtype  [NUM_CH];
  mtd_duty_s         duty   [NUM_CH];

  modport dev (
    input  cvalid,
    input  code,
    output dvalid,
    output rsvd,
    output mtype,
    output duty
  );

  modport req (
    output cvalid,
    output code,
    input  dvalid,
    input  rsvd,
    input  mtype,
    input  duty
  );

endinterface : mtd_if

// [hw/mtd_chan_dec.sv]
// Combinational attribute code decode for one channel.
// Assumes the code is stable from a flop in the same clock domain.
`timescale 1ns/10ps
module mtd_chan_dec
  import mtd_pkg::*;
#(
  parameter bit IS_WR = 1'b0
) (
  input  wire logic [CODE_W-1:0] code_in,
  output mtd_mem_e               mtype_out,
  output logic                   rsvd_out,
  output logic                   twin_out,
  output logic                   legacy_out
);

  // ==========================================
  // Code table
  always_comb
  begin
    mtype_out  = MT_DEV_NB;
    rsvd_out   = 1'b0;
    twin_out   = 1'b0;
    legacy_out = 1'b0;
    unique case (code_in)
      // R1 shared codes
      CODE_DEV_NB: mtype_out = MT_DEV_NB;
      CODE_DEV_B:  mtype_out = MT_DEV_B;
      CODE_NRM_NB: mtype_out = MT_NRM_NB;
      CODE_NRM_B:  mtype_out = MT_NRM_B;
      // R3 R4 low codes: write current, read older form
      CODE_WT_LO:
      begin
        mtype_out  = IS_WR ? MT_WT_NA : MT_WT_RA;
        twin_out   = IS_WR;
        legacy_out = !IS_WR;
      end
      CODE_WB_LO:
      begin
        mtype_out  = IS_WR ? MT_WB_NA : MT_WB_RA;
        twin_out   = IS_WR;
        legacy_out = !IS_WR;
      end
      // R2 R4 mid codes: read current, write older form
      CODE_WT_MID:
      begin
        mtype_out  = IS_WR ? MT_WT_WA : MT_WT_NA;
        twin_out   = !IS_WR;
        legacy_out = IS_WR;
      end
      CODE_WB_MID:
      begin
        mtype_out  = IS_WR ? MT_WB_WA : MT_WB_NA;
        twin_out   = !IS_WR;
        legacy_out = IS_WR;
      end
      // R2 R3 high codes: the other hint is unknown here
      CODE_WT_HI:
      begin
        mtype_out = IS_WR ? MT_WT_WA : MT_WT_RA;
        twin_out  = 1'b1;
      end
      CODE_WB_HI:
      begin
        mtype_out = IS_WR ? MT_WB_WA : MT_WB_RA;
        twin_out  = 1'b1;
      end
      // R5 anything else
      default: rsvd_out = 1'b1;
    endcase
  end

endmodule : mtd_chan_dec

// [hw/mtd_decoder.sv]
// Decoder end: turns read and write attribute codes into memory types
// and handling duties, one registered result per channel.
// Assumes codes arrive from flops on the same clock; no synchroniser needed.
`timescale 1ns/10ps
module mtd_decoder
  import mtd_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  mtd_if.dev              link,
  output mtd_mem_e        rd_type_out,
  output mtd_mem_e        wr_type_out,
  output logic [NUM_CH-1:0] rsvd_out,
  output logic [NUM_CH-1:0] twin_out,
  output logic [NUM_CH-1:0] legacy_out,
  output logic [CNT_W-1:0]  rd_rsvd_cnt_out,
  output logic [CNT_W-1:0]  wr_rsvd_cnt_out
);

  // ==========================================
  // Duty table
  // Reserved codes get the strictest handling so a stray code can
  // never widen what the memory system is allowed to do.
  function automatic mtd_duty_s duty_of(
    input mtd_mem_e mt,
    input logic     rsvd,
    input logic     modif_bit
  );
    mtd_duty_s d;
    d = '0;
    // R20 modifiable bit
    d.modif = modif_bit;
    if (rsvd)
    begin
      d.resp_final = 1'b1;
      d.rd_final   = 1'b1;
      d.ord_slave  = 1'b1;
      d.modif      = 1'b0;
    end
    else
    begin
      unique case (mt)
        // R7 R8 R9 device unbuffered
        MT_DEV_NB:
        begin
          d.resp_final = 1'b1;
          d.rd_final   = 1'b1;
          d.ord_slave  = 1'b1;
        end
        // R10 R8 R9 device buffered
        MT_DEV_B:
        begin
          d.rd_final   = 1'b1;
          d.wr_visible = 1'b1;
          d.ord_slave  = 1'b1;
        end
        // R11 R12 normal unbuffered
        MT_NRM_NB:
        begin
          d.resp_final  = 1'b1;
          d.rd_final    = 1'b1;
          d.merge_ok    = 1'b1;
          d.ord_overlap = 1'b1;
        end
        // R13 R14 R12 normal buffered
        MT_NRM_B:
        begin
          d.rd_fwd      = 1'b1;
          d.merge_ok    = 1'b1;
          d.wr_visible  = 1'b1;
          d.ord_overlap = 1'b1;
        end
        // R15 R16 write-through family
        MT_WT_NA, MT_WT_RA, MT_WT_WA, MT_WT_RWA:
        begin
          d.rd_cached   = 1'b1;
          d.pf_ok       = 1'b1;
          d.merge_ok    = 1'b1;
          d.lookup      = 1'b1;
          d.wr_visible  = 1'b1;
          d.ord_overlap = 1'b1;
        end
        // R15 R17 write-back family, no visibility duty
        MT_WB_NA, MT_WB_RA, MT_WB_WA, MT_WB_RWA:
        begin
          d.rd_cached   = 1'b1;
          d.pf_ok       = 1'b1;
          d.merge_ok    = 1'b1;
          d.lookup      = 1'b1;
          d.ord_overlap = 1'b1;
        end
      endcase
      // R19 allocation hints; R18 hints never forbid allocation
      unique case (mt)
        MT_WT_RA, MT_WB_RA:
        begin
          d.alloc_rd = 1'b1;
        end
        MT_WT_WA, MT_WB_WA:
        begin
          d.alloc_wr = 1'b1;
        end
        MT_WT_RWA, MT_WB_RWA:
        begin
          d.alloc_rd = 1'b1;
          d.alloc_wr = 1'b1;
        end
        default:
        begin
          d.alloc_rd = 1'b0;
        end
      endcase
    end
    return d;
  endfunction : duty_of

  // ==========================================
  // Per-channel decode
  mtd_mem_e          dec_type   [NUM_CH];
  logic [NUM_CH-1:0] dec_rsvd;
  logic [NUM_CH-1:0] dec_twin;
  logic [NUM_CH-1:0] dec_legacy;

  mtd_mem_e          type_r     [NUM_CH];
  mtd_mem_e          type_nxt   [NUM_CH];
  mtd_duty_s         duty_r     [NUM_CH];
  mtd_duty_s         duty_nxt   [NUM_CH];
  logic [NUM_CH-1:0] dvalid_r;
  logic [NUM_CH-1:0] dvalid_nxt;
  logic [NUM_CH-1:0] rsvd_r;
  logic [NUM_CH-1:0] rsvd_nxt;
  logic [NUM_CH-1:0] twin_r;
  logic [NUM_CH-1:0] twin_nxt;
  logic [NUM_CH-1:0] legacy_r;
  logic [NUM_CH-1:0] legacy_nxt;
  logic [CNT_W-1:0]  cnt_r      [NUM_CH];
  logic [CNT_W-1:0]  cnt_nxt    [NUM_CH];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      mtd_chan_dec #(
        .IS_WR (gi == CH_WR)
      ) u_dec (
        .code_in    (link.code[gi]),
        .mtype_out  (dec_type[gi]),
        .rsvd_out   (dec_rsvd[gi]),
        .twin_out   (dec_twin[gi]),
        .legacy_out (dec_legacy[gi])
      );

      // ==========================================
      // Next values
      // Results only move on a presented code; between codes the
      // last decode stands, so the far end may sample it late.
      always_comb
      begin
        type_nxt[gi]   = type_r[gi];
        duty_nxt[gi]   = duty_r[gi];
        rsvd_nxt[gi]   = rsvd_r[gi];
        twin_nxt[gi]   = twin_r[gi];
        legacy_nxt[gi] = legacy_r[gi];
        cnt_nxt[gi]    = cnt_r[gi];
        dvalid_nxt[gi] = link.cvalid[gi];
        if (link.cvalid[gi])
        begin
          // R6 every listed form is accepted, none refused
          type_nxt[gi]   = dec_type[gi];
          duty_nxt[gi]   = duty_of(dec_type[gi], dec_rsvd[gi], link.code[gi][BIT_MOD]);
          twin_nxt[gi]   = dec_twin[gi];
          legacy_nxt[gi] = dec_legacy[gi];
          // R5 reserved flag and saturating tally
          rsvd_nxt[gi]   = dec_rsvd[gi];
          if (dec_rsvd[gi] && cnt_r[gi] != CNT_MAX)
          begin
            cnt_nxt[gi] = cnt_r[gi] + CNT_ONE;
          end
        end
      end

      // ==========================================
      // Registers
      // R21 registered one edge later, cleared on reset
      always_ff @(posedge clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          type_r[gi]   <= MT_DEV_NB;
          duty_r[gi]   <= '0;
          dvalid_r[gi] <= 1'b0;
          rsvd_r[gi]   <= 1'b0;
          twin_r[gi]   <= 1'b0;
          legacy_r[gi] <= 1'b0;
          cnt_r[gi]    <= CNT_ZERO;
        end
        else
        begin
          type_r[gi]   <= type_nxt[gi];
          duty_r[gi]   <= duty_nxt[gi];
          dvalid_r[gi] <= dvalid_nxt[gi];
          rsvd_r[gi]   <= rsvd_nxt[gi];
          twin_r[gi]   <= twin_nxt[gi];
          legacy_r[gi] <= legacy_nxt[gi];
          cnt_r[gi]    <= cnt_nxt[gi];
        end
      end

      // ==========================================
      // Link outputs
      assign link.mtype[gi] = type_r[gi];
      assign link.duty[gi]  = duty_r[gi];
    end
  endgenerate

  // ==========================================
  // Outputs, all straight from flops
  assign link.dvalid     = dvalid_r;
  assign link.rsvd       = rsvd_r;
  assign rd_type_out     = type_r[CH_RD];
  assign wr_type_out     = type_r[CH_WR];
  assign rsvd_out        = rsvd_r;
  assign twin_out        = twin_r;
  assign legacy_out      = legacy_r;
  assign rd_rsvd_cnt_out = cnt_r[CH_RD];
  assign wr_rsvd_cnt_out = cnt_r[CH_WR];

endmodule : mtd_decoder

// [hw/mtd_mem_port.sv]
// Requesting end: presents attribute codes to the decoder and applies
// the returned duties to the memory system's own requests.
// Assumes user inputs come from logic on clk_in.
`timescale 1ns/10ps
module mtd_mem_port
  import mtd_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  mtd_if.req                     link,
  input  wire logic              rd_valid_in,
  input  wire logic [CODE_W-1:0] rd_code_in,
  input  wire logic              wr_valid_in,
  input  wire logic [CODE_W-1:0] wr_code_in,
  input  wire logic              pf_req_in,
  input  wire logic              fwd_req_in,
  input  wire logic              hit_in,
  input  wire logic              merge_req_in,
  input  wire logic              early_req_in,
  output logic                   pf_gnt_out,
  output logic                   fwd_gnt_out,
  output logic                   cached_gnt_out,
  output logic                   merge_gnt_out,
  output logic                   early_gnt_out,
  output logic                   drain_out,
  output logic [NUM_CH-1:0]      lookup_out,
  output logic [NUM_CH-1:0]      ord_slave_out,
  output logic [NUM_CH-1:0]      ord_overlap_out,
  output logic                   alloc_rd_out,
  output logic                   alloc_wr_out
);

  typedef struct packed {
    logic              pf;
    logic              fwd;
    logic              cached;
    logic              merge;
    logic              early;
    logic              drain;
    logic [NUM_CH-1:0] lookup;
    logic [NUM_CH-1:0] ord_slave;
    logic [NUM_CH-1:0] ord_overlap;
    logic              alloc_rd;
    logic              alloc_wr;
  } mtd_gate_s;

  logic [NUM_CH-1:0] cvalid_r;
  logic [NUM_CH-1:0] cvalid_nxt;
  logic [CODE_W-1:0] code_r   [NUM_CH];
  logic [CODE_W-1:0] code_nxt [NUM_CH];
  mtd_gate_s         gate_r;
  mtd_gate_s         gate_nxt;
  mtd_duty_s         rd;
  mtd_duty_s         wr;

  assign rd = link.duty[CH_RD];
  assign wr = link.duty[CH_WR];

  // ==========================================
  // Next values
  always_comb
  begin
    cvalid_nxt        = {wr_valid_in, rd_valid_in};
    code_nxt[CH_RD]   = rd_valid_in ? rd_code_in : code_r[CH_RD];
    code_nxt[CH_WR]   = wr_valid_in ? wr_code_in : code_r[CH_WR];
    // R8 R15 prefetch only where allowed
    gate_nxt.pf       = pf_req_in & rd.pf_ok;
    // R13 forward from in-flight write, never a kept copy
    gate_nxt.fwd      = fwd_req_in & rd.rd_fwd;
    // R7 R10 R11 R15 cached data only where not bound to destination
    gate_nxt.cached   = hit_in & rd.rd_cached & ~rd.rd_final;
    // R8 R11 R14 merge only where allowed
    gate_nxt.merge    = merge_req_in & wr.merge_ok;
    // R7 R10 R14 R16 R17 early response unless destination required
    gate_nxt.early    = early_req_in & ~wr.resp_final;
    // R14 R16 buffered writes must drain; R17 write-back may stay
    gate_nxt.drain    = wr.wr_visible;
    // R15 lookup duty per channel
    gate_nxt.lookup   = {wr.lookup, rd.lookup};
    // R9 R12 ordering duties
    gate_nxt.ord_slave   = {wr.ord_slave, rd.ord_slave};
    gate_nxt.ord_overlap = {wr.ord_overlap, rd.ord_overlap};
    // R18 hints only; allocation stays the cache's choice
    gate_nxt.alloc_rd = rd.alloc_rd;
    gate_nxt.alloc_wr = wr.alloc_wr;
  end

  // ==========================================
  // Registers
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cvalid_r      <= '0;
      code_r[CH_RD] <= CODE_DEV_NB;
      code_r[CH_WR] <= CODE_DEV_NB;
      gate_r        <= '0;
    end
    else
    begin
      cvalid_r      <= cvalid_nxt;
      code_r[CH_RD] <= code_nxt[CH_RD];
      code_r[CH_WR] <= code_nxt[CH_WR];
      gate_r        <= gate_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign link.cvalid       = cvalid_r;
  assign link.code[CH_RD]  = code_r[CH_RD];
  assign link.code[CH_WR]  = code_r[CH_WR];
  assign pf_gnt_out        = gate_r.pf;
  assign fwd_gnt_out       = gate_r.fwd;
  assign cached_gnt_out    = gate_r.cached;
  assign merge_gnt_out     = gate_r.merge;
  assign early_gnt_out     = gate_r.early;
  assign drain_out         = gate_r.drain;
  assign lookup_out        = gate_r.lookup;
  assign ord_slave_out     = gate_r.ord_slave;
  assign ord_overlap_out   = gate_r.ord_overlap;
  assign alloc_rd_out      = gate_r.alloc_rd;
  assign alloc_wr_out      = gate_r.alloc_wr;

endmodule : mtd_mem_port

// [dv/mtd_checker.sv]
// Checker on the link between requesting end and decoder end.
// Assumes one clock, reset active low, link signals wired in as plain inputs.
`timescale 1ns/10ps
module mtd_checker
  import mtd_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rstn_in,
  input wire logic [NUM_CH-1:0] cvalid,
  input wire logic [CODE_W-1:0] code   [NUM_CH],
  input wire logic [NUM_CH-1:0] dvalid,
  input wire logic [NUM_CH-1:0] rsvd,
  input mtd_mem_e               mtype  [NUM_CH],
  input mtd_duty_s              duty   [NUM_CH]
);
  // ==========================================
  // Helpers
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  logic [3:0] wr_type;
  logic       wr_mod_bit;
  assign wr_type    = mtype[1];
  assign wr_mod_bit = code[1][1];

  sequence rd_sent(logic [3:0] c);
    cvalid[0] && code[0] == c;
  endsequence
  sequence wr_sent(logic [3:0] c);
    cvalid[1] && code[1] == c;
  endsequence

  // ==========================================
  // Decode checks
  // result one edge after code
  result_timing_a: assert property (dvalid == $past(cvalid)) else $error("result pulse misplaced");
  plain_codes_a: assert property (cvalid[0] && code[0][3:2] == 2'b00 |=>
    4'(mtype[0]) == $past(code[0]) && !rsvd[0]) else $error("plain read code misdecoded");
  rd_cached_a: assert property (rd_sent(4'hE) |=> mtype[0] == MT_WT_RA && duty[0].lookup)
    else $error("read cached code misdecoded");
  wr_cached_a: assert property (wr_sent(4'h6) |=> mtype[1] == MT_WT_NA && !duty[1].alloc_wr)
    else $error("write cached code misdecoded");
  legacy_code_a: assert property (wr_sent(4'hA) |=> mtype[1] == MT_WT_WA && !rsvd[1])
    else $error("older write form refused");
  rd_reserved_a: assert property (cvalid[0] && !code[0][1] && code[0][3:2] != 2'b00 |=>
    rsvd[0] && !duty[0].modif) else $error("read reserved not flagged");
  wr_reserved_a: assert property (cvalid[1] && !code[1][1] && code[1][3:2] != 2'b00 |=>
    rsvd[1] && duty[1].resp_final) else $error("write reserved not flagged");
  modif_bit_a: assert property (dvalid[1] && !rsvd[1] |-> duty[1].modif == $past(wr_mod_bit))
    else $error("modifiable duty wrong");
  device_strict_a: assert property (dvalid[0] && !duty[0].modif |->
    !duty[0].pf_ok && !duty[0].merge_ok && duty[0].ord_slave) else $error("device duties loose");
  alloc_hint_a: assert property (dvalid[1] && !rsvd[1] && wr_type >= 4'h4 |->
    duty[1].alloc_wr == wr_type[1] && !duty[1].alloc_rd) else $error("write hint wrong");
  result_hold_a: assert property (!dvalid[0] |-> $stable(mtype[0])) else $error("type changed idle");
endmodule : mtd_checker

// [dv/memory_type_decoder_test.sv]
// Testbench joining both ends through the link, driving user codes.
// Assumes 125 MHz clock; expectations built from the decode table here.
`timescale 1ns/10ps
module memory_type_decoder_test;
  import mtd_pkg::*;
  logic              clk_in, rstn_in, rd_valid_in, wr_valid_in, pf_req_in, fwd_req_in, hit_in;
  logic              merge_req_in, early_req_in, pf_gnt_out, fwd_gnt_out, cached_gnt_out, merge_gnt_out;
  logic              early_gnt_out, drain_out, alloc_rd_out, alloc_wr_out;
  logic [CODE_W-1:0] rd_code_in, wr_code_in;
  mtd_mem_e          rd_type_out, wr_type_out;
  logic [NUM_CH-1:0] rsvd_out, twin_out, legacy_out, lookup_out, ord_slave_out, ord_overlap_out;
  logic [CNT_W-1:0]  rd_rsvd_cnt_out, wr_rsvd_cnt_out;
  int                errors, checks, cycles;

  mtd_if link ();
  mtd_decoder mtd_decoder_inst (.clk_in, .rstn_in, .link(link), .rd_type_out, .wr_type_out, .rsvd_out,
    .twin_out, .legacy_out, .rd_rsvd_cnt_out, .wr_rsvd_cnt_out);
  mtd_mem_port mtd_mem_port_inst (.clk_in, .rstn_in, .link(link), .rd_valid_in, .rd_code_in, .wr_valid_in,
    .wr_code_in, .pf_req_in, .fwd_req_in, .hit_in, .merge_req_in, .early_req_in, .pf_gnt_out, .fwd_gnt_out,
    .cached_gnt_out, .merge_gnt_out, .early_gnt_out, .drain_out, .lookup_out, .ord_slave_out,
    .ord_overlap_out, .alloc_rd_out, .alloc_wr_out);
  mtd_checker mtd_checker_inst (.clk_in, .rstn_in, .cvalid(link.cvalid), .code(link.code),
    .dvalid(link.dvalid), .rsvd(link.rsvd), .mtype(link.mtype), .duty(link.duty));

  // ==========================================
  // Clock, timeout, reporting
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Sweep needs 64 cycles, whole run 84; generous ceiling
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // ==========================================
  // Expected decode: {rsvd, type, modif, cached, alloc_rd, alloc_wr, resp_final, twin, legacy}
  function automatic logic [11:0] exp_bits(input bit wr, input logic [3:0] c);
    logic [4:0] rt;
    logic       cch;
    logic       mod;
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: rt = {1'b0, c};
      4'h6: rt = {1'b0, wr ? MT_WT_NA : MT_WT_RA};
      4'h7: rt = {1'b0, wr ? MT_WB_NA : MT_WB_RA};
      4'hA: rt = {1'b0, wr ? MT_WT_WA : MT_WT_NA};
      4'hB: rt = {1'b0, wr ? MT_WB_WA : MT_WB_NA};
      4'hE: rt = {1'b0, wr ? MT_WT_WA : MT_WT_RA};
      4'hF: rt = {1'b0, wr ? MT_WB_WA : MT_WB_RA};
      default: rt = 5'h10;
    endcase
    cch = !rt[4] && rt[3:0] >= 4'h4;
    mod = !rt[4] && c[1];
    return {rt, mod, cch, cch && rt[0], cch && rt[1], rt[4] || rt[3:0] == 4'h0 || rt[3:0] == 4'h2,
            c[1] && (wr ? c[2] : c[3]), c[1] && (wr ? c[3] && !c[2] : c[2] && !c[3])};
  endfunction : exp_bits

  // ==========================================
  // Scenarios
  // Same code on both channels, then decode and gate results judged
  task automatic send_code(input logic [3:0] c);
    logic [11:0] er;
    logic [11:0] ew;
    logic        wv;
    er = exp_bits(1'b0, c);
    ew = exp_bits(1'b1, c);
    // Write must drain for device buffered, normal buffered, write-through
    wv = ew[10:9] == 2'b01 || (ew[10:9] == 2'b00 && ew[7]);
    @(posedge clk_in);
    rd_valid_in <= 1'b1;
    wr_valid_in <= 1'b1;
    rd_code_in  <= c;
    wr_code_in  <= c;
    @(posedge clk_in);
    rd_valid_in <= 1'b0;
    wr_valid_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check({link.dvalid, rd_type_out, wr_type_out}, {2'b11, er[10:7], ew[10:7]});
    check({link.rsvd[0], link.mtype[0], link.duty[0].modif, link.duty[0].lookup, link.duty[0].alloc_rd,
      link.duty[0].alloc_wr, link.duty[0].resp_final, twin_out[0], legacy_out[0]}, er);
    check({link.rsvd[1], link.mtype[1], link.duty[1].modif, link.duty[1].lookup, link.duty[1].alloc_rd,
      link.duty[1].alloc_wr, link.duty[1].resp_final, twin_out[1], legacy_out[1]}, ew);
    check({link.duty[1].pf_ok, link.duty[1].merge_ok, link.duty[1].ord_slave, link.duty[1].ord_overlap},
      {ew[5], ew[6], !ew[6], ew[6]});
    check({link.duty[0].rd_final, link.duty[1].wr_visible}, {er[10:7] <= 4'h2, wv});
    @(posedge clk_in);
    #1;
    check({pf_gnt_out, fwd_gnt_out, cached_gnt_out, merge_gnt_out, early_gnt_out, lookup_out, alloc_rd_out,
      alloc_wr_out}, {er[5], er[10:7] == 4'h3 && !er[11], er[5], ew[6], !ew[2], ew[5], er[5], er[4],
      ew[3]});
    check({ord_slave_out, ord_overlap_out, drain_out}, {!ew[6], !er[6], ew[6], er[6], wv});
  endtask : send_code

  // Requests dropped: all five request grants must close even where duties allow
  task automatic req_low();
    @(posedge clk_in);
    {pf_req_in, fwd_req_in, hit_in, merge_req_in, early_req_in} <= 5'h00;
    @(posedge clk_in);
    @(posedge clk_in);
    #1;
    check({pf_gnt_out, fwd_gnt_out, cached_gnt_out, merge_gnt_out, early_gnt_out}, 5'h00);
    @(posedge clk_in);
    {pf_req_in, fwd_req_in, hit_in, merge_req_in, early_req_in} <= 5'h1F;
  endtask : req_low

  // Two read codes on consecutive cycles
  task automatic back_to_back();
    @(posedge clk_in);
    rd_valid_in <= 1'b1;
    rd_code_in  <= 4'h3;
    @(posedge clk_in);
    rd_code_in  <= 4'h7;
    @(posedge clk_in);
    rd_valid_in <= 1'b0;
    #1;
    check({link.dvalid[0], rd_type_out, link.rsvd[0]}, {1'b1, MT_NRM_B, 1'b0});
    @(posedge clk_in);
    #1;
    check({link.dvalid[0], rd_type_out, legacy_out[0], fwd_gnt_out}, {1'b1, MT_WB_RA, 2'b11});
    @(posedge clk_in);
    #1;
    check({link.dvalid[0], fwd_gnt_out, rd_type_out}, {2'b00, MT_WB_RA});
  endtask : back_to_back

  // Reset in mid-run clears every result
  task automatic mid_reset();
    @(posedge clk_in);
    rstn_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check({rsvd_out, twin_out, legacy_out, rd_rsvd_cnt_out, wr_rsvd_cnt_out, rd_type_out, wr_type_out},
      32'h0000_0000);
    check({link.dvalid, pf_gnt_out, fwd_gnt_out, cached_gnt_out, merge_gnt_out, early_gnt_out, drain_out,
      lookup_out, ord_slave_out, ord_overlap_out, alloc_rd_out, alloc_wr_out}, 32'h0000_0000);
    @(posedge clk_in);
    rstn_in <= 1'b1;
  endtask : mid_reset

  // ==========================================
  // Main sequence
  initial
  begin
    {rstn_in, rd_valid_in, wr_valid_in, rd_code_in, wr_code_in} = '0;
    {pf_req_in, fwd_req_in, hit_in, merge_req_in, early_req_in} = 5'h1F;
    errors = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (int c = 0; c < 16; c++)
      send_code(4'(c));
    // Six reserved codes on each channel
    check({rd_rsvd_cnt_out, wr_rsvd_cnt_out}, {8'h06, 8'h06});
    req_low();
    back_to_back();
    mid_reset();
    send_code(4'hB);
    end_of_test();
  end
endmodule : memory_type_decoder_test
